//--- nrc_read_fsm.sv
// Read command sequence interpreter of the flash target, with APB registers.
`timescale 1ns/1ps

// Contract
// - Entry: status flag set goes status-off, clears.
// - Status-off: address cycle goes to address store.
// - Status-off read: 80h program wait, else data.
// - Status-off read after EEh returns feature data.
// - Address wait: opcode 00h, column-change flags true.
// - Address wait: busy sets enhanced-status-required flag.
// - Store address; loop until all cycles received.
// - Select unit from row, issue page read.
// - Idle unselected units disable output buffers.
// - Wait for confirm 30h, 31h, 32h, 35h.
// - Pass confirm; 35h copyback, else idle read.
// - Copyback: set copyback flag, record resume state.
// - Copyback: 85h programs, 00h restarts read.
// - Copyback: ready-bit change goes to transition handling.
// - Copyback read: status if flag, else data.
module nrc_read_fsm #(
  parameter int UNITS = 4,
  parameter int UNIT_W = 2,
  parameter int ROW_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  input wire logic read_req,
  input wire logic ready_busy_n,
  input wire logic [UNITS-1:0] unit_idle,
  input wire logic unit_ready_change,
  output logic unit_read_start,
  output logic [ROW_W-1:0] unit_read_row,
  output logic [UNITS-1:0] unit_select,
  output logic [UNITS-1:0] unit_out_disable,
  output logic unit_cmd_valid,
  output logic [7:0] unit_cmd_opcode,
  output logic route_valid,
  output logic [1:0] route_code,
  output logic handoff_valid,
  output logic [2:0] handoff_code
);

  nrc_pkg::nrc_state_t state;
  nrc_pkg::nrc_state_t next_state;
  nrc_pkg::nrc_state_t resume_state;
  logic status_output_flag;
  logic enhanced_status_required;
  logic column_change_allowed;
  logic column_change_enh_allowed;
  logic copyback_flag;
  logic [7:0] previous_opcode;
  logic [2:0] addr_cycles_needed;
  logic [2:0] addr_count;
  logic [ROW_W-1:0] row_addr;
  logic [UNIT_W-1:0] selected_unit;
  logic [7:0] confirm_opcode;

  // APB decode. The slave answers in the cycle after setup, always.
  wire setup_phase = psel & ~penable;
  wire wr_take = psel & penable & pready & pwrite;
  wire hit_ctrl = paddr == nrc_pkg::REG_CTRL;
  wire hit_opcode = paddr == nrc_pkg::REG_OPCODE;
  wire hit_cfg = paddr == nrc_pkg::REG_CFG;
  wire hit_status = paddr == nrc_pkg::REG_STATUS;
  wire hit_row = paddr == nrc_pkg::REG_ROW;
  wire addr_mapped = hit_ctrl | hit_opcode | hit_cfg | hit_status | hit_row;
  wire wr_ctrl = wr_take & hit_ctrl;
  wire sw_set_status = wr_ctrl & pwdata[nrc_pkg::CTRL_STATUS_OUT];
  wire sw_clr_enh = wr_ctrl & pwdata[nrc_pkg::CTRL_ENH_CLR];
  wire sw_clr_copyback = wr_ctrl & pwdata[nrc_pkg::CTRL_COPYBACK_CLR];

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[nrc_pkg::ST_STATE_LSB +: 4] = state;
    status_word[nrc_pkg::ST_RESUME_LSB +: 4] = resume_state;
    status_word[nrc_pkg::ST_STATUS_OUT] = status_output_flag;
    status_word[nrc_pkg::ST_ENH_REQ] = enhanced_status_required;
    status_word[nrc_pkg::ST_COL_CHG] = column_change_allowed;
    status_word[nrc_pkg::ST_COL_CHG_ENH] = column_change_enh_allowed;
    status_word[nrc_pkg::ST_COPYBACK] = copyback_flag;
    status_word[nrc_pkg::ST_UNIT_LSB +: UNIT_W] = selected_unit;
  end

  wire [31:0] read_mux =
    hit_ctrl ? {31'h0000_0000, status_output_flag} :
    hit_opcode ? {24'h00_0000, previous_opcode} :
    hit_cfg ? {29'h0000_0000, addr_cycles_needed} :
    hit_status ? status_word :
    hit_row ? {{(32 - ROW_W){1'b0}}, row_addr} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~addr_mapped;
      prdata <= setup_phase ? read_mux : 32'h0000_0000;
    end
  end

  // Decoded host events in the states that care about them.
  wire in_status_off = state == nrc_pkg::NRC_STATUS_OFF;
  wire in_copyback = state == nrc_pkg::NRC_COPYBACK;
  wire in_addr_wait = state == nrc_pkg::NRC_ADDR_WAIT;
  wire in_addr_store = state == nrc_pkg::NRC_ADDR_STORE;
  wire in_issue = state == nrc_pkg::NRC_UNIT_ISSUE;
  wire in_pass = state == nrc_pkg::NRC_CMD_PASS;
  wire op_chg_col = cmd_valid & (cmd_opcode == nrc_pkg::OP_CHG_COL);
  wire op_chg_enh = cmd_valid & (cmd_opcode == nrc_pkg::OP_CHG_COL_ENH);
  wire op_status = cmd_valid & (cmd_opcode == nrc_pkg::OP_STATUS);
  wire op_status_enh = cmd_valid & (cmd_opcode == nrc_pkg::OP_STATUS_ENH);
  wire op_read = cmd_valid & (cmd_opcode == nrc_pkg::OP_READ);
  wire op_cb_prog = cmd_valid & (cmd_opcode == nrc_pkg::OP_COPYBACK_PROG);
  wire op_confirm = cmd_valid & ((cmd_opcode == nrc_pkg::OP_CONFIRM_30) |
    (cmd_opcode == nrc_pkg::OP_CONFIRM_31) | (cmd_opcode == nrc_pkg::OP_CONFIRM_32) |
    (cmd_opcode == nrc_pkg::OP_COPYBACK_RD));
  wire more_cycles = (addr_count + 3'h1) < addr_cycles_needed;
  wire [UNIT_W-1:0] row_unit = row_addr[ROW_W-1 -: UNIT_W];
  wire [UNITS-1:0] row_unit_onehot = UNITS'(1) << row_unit;
  localparam logic [2:0] COL_START = nrc_pkg::COL_CYCLES;
  wire [2:0] row_slot = addr_count - COL_START;
  wire [1:0] row_index = (row_slot < 3'(ROW_W / 8)) ? row_slot[1:0] : 2'h0;

  // Read request routing in the two waiting states.
  wire so_read = in_status_off & read_req;
  wire cb_read = in_copyback & read_req;
  wire [1:0] so_route =
    (previous_opcode == nrc_pkg::OP_PROGRAM) ? nrc_pkg::ROUTE_PROGRAM :
    (previous_opcode == nrc_pkg::OP_GET_FEATURE) ? nrc_pkg::ROUTE_FEATURE :
    nrc_pkg::ROUTE_UNIT_DATA;
  wire [1:0] cb_route = status_output_flag ? nrc_pkg::ROUTE_STATUS :
    nrc_pkg::ROUTE_UNIT_DATA;

  // Leaving the read flow towards another sequence.
  logic leave;
  logic [2:0] leave_code;
  always_comb begin
    leave = 1'b1;
    leave_code = nrc_pkg::NEXT_IDLE_READ;
    if ((in_status_off | in_copyback) & op_chg_col) begin
      leave_code = nrc_pkg::NEXT_CHG_COL;
    end else if ((in_status_off | in_copyback) & op_chg_enh) begin
      leave_code = nrc_pkg::NEXT_CHG_COL_ENH;
    end else if (in_copyback & op_status) begin
      leave_code = nrc_pkg::NEXT_STATUS;
    end else if (in_copyback & op_status_enh) begin
      leave_code = nrc_pkg::NEXT_STATUS_ENH;
    end else if (in_copyback & op_cb_prog) begin
      leave_code = nrc_pkg::NEXT_COPYBACK_PROG;
    end else if (in_copyback & unit_ready_change) begin
      leave_code = nrc_pkg::NEXT_RB_TRANSITION;
    end else if (in_pass & (confirm_opcode != nrc_pkg::OP_COPYBACK_RD)) begin
      leave_code = nrc_pkg::NEXT_IDLE_READ;
    end else begin
      leave = 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      nrc_pkg::NRC_IDLE: begin
        if (op_read) begin
          next_state = nrc_pkg::NRC_RD_EXECUTE;
        end
      end
      nrc_pkg::NRC_RD_EXECUTE: begin
        next_state = status_output_flag ? nrc_pkg::NRC_STATUS_OFF :
          nrc_pkg::NRC_ADDR_WAIT;
      end
      nrc_pkg::NRC_STATUS_OFF: begin
        if (leave | so_read) begin
          next_state = nrc_pkg::NRC_IDLE;
        end else if (addr_valid) begin
          next_state = nrc_pkg::NRC_ADDR_STORE;
        end
      end
      nrc_pkg::NRC_ADDR_WAIT: begin
        if (addr_valid) begin
          next_state = nrc_pkg::NRC_ADDR_STORE;
        end
      end
      nrc_pkg::NRC_ADDR_STORE: begin
        next_state = more_cycles ? nrc_pkg::NRC_ADDR_WAIT :
          nrc_pkg::NRC_UNIT_ISSUE;
      end
      nrc_pkg::NRC_UNIT_ISSUE: begin
        next_state = nrc_pkg::NRC_CONFIRM_WAIT;
      end
      nrc_pkg::NRC_CONFIRM_WAIT: begin
        if (op_confirm) begin
          next_state = nrc_pkg::NRC_CMD_PASS;
        end
      end
      nrc_pkg::NRC_CMD_PASS: begin
        next_state = leave ? nrc_pkg::NRC_IDLE : nrc_pkg::NRC_COPYBACK;
      end
      nrc_pkg::NRC_COPYBACK: begin
        if (op_read) begin
          next_state = nrc_pkg::NRC_RD_EXECUTE;
        end else if (leave | cb_read) begin
          next_state = nrc_pkg::NRC_IDLE;
        end
      end
      default: begin
        next_state = nrc_pkg::NRC_IDLE;
      end
    endcase
  end

  // Sequencer state, flags and captured address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= nrc_pkg::NRC_IDLE;
      resume_state <= nrc_pkg::NRC_IDLE;
      status_output_flag <= 1'b0;
      enhanced_status_required <= 1'b0;
      column_change_allowed <= 1'b0;
      column_change_enh_allowed <= 1'b0;
      copyback_flag <= 1'b0;
      previous_opcode <= nrc_pkg::OPCODE_RESET;
      addr_cycles_needed <= nrc_pkg::ADDR_CYCLES_RESET;
      addr_count <= 3'h0;
      row_addr <= '0;
      selected_unit <= '0;
      confirm_opcode <= 8'h00;
    end else begin
      state <= next_state;
      // Software sets the flag; the entry clear loses to a same-cycle set.
      if (sw_set_status) begin
        status_output_flag <= 1'b1;
      end else if (in_status_off) begin
        status_output_flag <= 1'b0;
      end
      if (in_status_off) begin
        resume_state <= nrc_pkg::NRC_STATUS_OFF;
      end else if (in_copyback) begin
        resume_state <= nrc_pkg::NRC_COPYBACK;
      end
      if (in_addr_wait & ~ready_busy_n) begin
        enhanced_status_required <= 1'b1;
      end else if (sw_clr_enh) begin
        enhanced_status_required <= 1'b0;
      end
      if (in_copyback) begin
        copyback_flag <= 1'b1;
      end else if (sw_clr_copyback) begin
        copyback_flag <= 1'b0;
      end
      if (in_addr_wait) begin
        previous_opcode <= nrc_pkg::OP_READ;
        column_change_allowed <= 1'b1;
        column_change_enh_allowed <= 1'b1;
      end else if (wr_take & hit_opcode) begin
        previous_opcode <= pwdata[7:0];
      end
      if (wr_take & hit_cfg) begin
        addr_cycles_needed <= pwdata[2:0];
      end
      if (state == nrc_pkg::NRC_RD_EXECUTE) begin
        addr_count <= 3'h0;
      end else if (in_addr_store) begin
        addr_count <= addr_count + 3'h1;
      end
      // Row bytes follow the column bytes, lowest byte first.
      if (addr_valid & (in_addr_wait | in_status_off) & (addr_count >= COL_START)) begin
        row_addr[8 * row_index +: 8] <= addr_byte;
      end
      if (in_issue) begin
        selected_unit <= row_unit;
      end
      if (op_confirm & (state == nrc_pkg::NRC_CONFIRM_WAIT)) begin
        confirm_opcode <= cmd_opcode;
      end
    end
  end

  // Unit requests and host-facing pulses, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_read_start <= 1'b0;
      unit_read_row <= '0;
      unit_select <= '0;
      unit_out_disable <= '0;
      unit_cmd_valid <= 1'b0;
      unit_cmd_opcode <= 8'h00;
      route_valid <= 1'b0;
      route_code <= nrc_pkg::ROUTE_STATUS;
      handoff_valid <= 1'b0;
      handoff_code <= nrc_pkg::NEXT_IDLE_READ;
    end else begin
      unit_read_start <= in_issue;
      unit_cmd_valid <= in_pass;
      route_valid <= (so_read | cb_read) & ~leave;
      handoff_valid <= leave;
      if (in_issue) begin
        unit_read_row <= row_addr;
        unit_select <= row_unit_onehot;
        // Busy units ignore the request; the host covers them with 78h first.
        unit_out_disable <= unit_idle & ~row_unit_onehot;
      end else begin
        unit_out_disable <= '0;
      end
      if (in_pass) begin
        unit_cmd_opcode <= confirm_opcode;
      end
      if (so_read) begin
        route_code <= so_route;
      end else if (cb_read) begin
        route_code <= cb_route;
      end
      if (leave) begin
        handoff_code <= leave_code;
      end
    end
  end

endmodule

//--- nrc_pkg.sv
// Constants and types shared by the read command interpreter.
package nrc_pkg;

  // Register byte offsets on the APB side.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_OPCODE = 12'h004;
  localparam logic [11:0] REG_CFG = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_ROW = 12'h010;

  // Control register bit positions.
  localparam int CTRL_STATUS_OUT = 0;
  localparam int CTRL_ENH_CLR = 1;
  localparam int CTRL_COPYBACK_CLR = 2;

  // Status register field positions.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_RESUME_LSB = 4;
  localparam int ST_STATUS_OUT = 8;
  localparam int ST_ENH_REQ = 9;
  localparam int ST_COL_CHG = 10;
  localparam int ST_COL_CHG_ENH = 11;
  localparam int ST_COPYBACK = 12;
  localparam int ST_UNIT_LSB = 16;

  // Reset values and the column cycle count.
  localparam logic [7:0] OPCODE_RESET = 8'h00;
  localparam logic [2:0] ADDR_CYCLES_RESET = 3'h5;
  localparam logic [2:0] COL_CYCLES = 3'h2;

  // Opcodes seen by the read sequence.
  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_CHG_COL = 8'h05;
  localparam logic [7:0] OP_CHG_COL_ENH = 8'h06;
  localparam logic [7:0] OP_CONFIRM_30 = 8'h30;
  localparam logic [7:0] OP_CONFIRM_31 = 8'h31;
  localparam logic [7:0] OP_CONFIRM_32 = 8'h32;
  localparam logic [7:0] OP_COPYBACK_RD = 8'h35;
  localparam logic [7:0] OP_STATUS = 8'h70;
  localparam logic [7:0] OP_STATUS_ENH = 8'h78;
  localparam logic [7:0] OP_PROGRAM = 8'h80;
  localparam logic [7:0] OP_COPYBACK_PROG = 8'h85;
  localparam logic [7:0] OP_GET_FEATURE = 8'hEE;

  // Where a read request is routed.
  localparam logic [1:0] ROUTE_STATUS = 2'h0;
  localparam logic [1:0] ROUTE_FEATURE = 2'h1;
  localparam logic [1:0] ROUTE_PROGRAM = 2'h2;
  localparam logic [1:0] ROUTE_UNIT_DATA = 2'h3;

  // Sequence the block hands control to when it leaves the read flow.
  localparam logic [2:0] NEXT_CHG_COL = 3'h0;
  localparam logic [2:0] NEXT_CHG_COL_ENH = 3'h1;
  localparam logic [2:0] NEXT_COPYBACK_PROG = 3'h2;
  localparam logic [2:0] NEXT_STATUS = 3'h3;
  localparam logic [2:0] NEXT_STATUS_ENH = 3'h4;
  localparam logic [2:0] NEXT_RB_TRANSITION = 3'h5;
  localparam logic [2:0] NEXT_IDLE_READ = 3'h6;

  typedef enum logic [3:0] {
    NRC_IDLE = 4'b0000,
    NRC_RD_EXECUTE = 4'b0001,
    NRC_STATUS_OFF = 4'b0010,
    NRC_ADDR_WAIT = 4'b0011,
    NRC_ADDR_STORE = 4'b0100,
    NRC_UNIT_ISSUE = 4'b0101,
    NRC_CONFIRM_WAIT = 4'b0110,
    NRC_CMD_PASS = 4'b0111,
    NRC_COPYBACK = 4'b1000
  } nrc_state_t;

endpackage

//--- nrc_read_fsm_assertions.sv
// Concurrent checks on the ports of the read command interpreter.
`timescale 1ns/1ps
module nrc_read_fsm_assertions #(
  parameter int UNITS = 4,
  parameter int UNIT_W = 2,
  parameter int ROW_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic addr_valid,
  input wire logic read_req,
  input wire logic unit_ready_change,
  input wire logic unit_read_start,
  input wire logic [ROW_W-1:0] unit_read_row,
  input wire logic [UNITS-1:0] unit_select,
  input wire logic [UNITS-1:0] unit_out_disable,
  input wire logic unit_cmd_valid,
  input wire logic [7:0] unit_cmd_opcode,
  input wire logic route_valid,
  input wire logic handoff_valid,
  input wire logic [2:0] handoff_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_row;
    unit_read_start |-> unit_select == (UNITS'(1) << unit_read_row[ROW_W-1 -: UNIT_W]);
  endproperty
  a_row: assert property (p_row) else $error("unit select does not match row");
  property p_addr; unit_read_start |-> $past(addr_valid, 2) || $past(addr_valid, 3); endproperty
  a_addr: assert property (p_addr) else $error("read start without address");
  property p_excl; unit_read_start |-> (unit_out_disable & unit_select) == '0; endproperty
  a_excl: assert property (p_excl) else $error("selected unit disabled");
  property p_dis; !unit_read_start |-> unit_out_disable == '0; endproperty
  a_dis: assert property (p_dis) else $error("disable outside page read");
  property p_code; unit_cmd_valid |-> unit_cmd_opcode inside {8'h30, 8'h31, 8'h32, 8'h35}; endproperty
  a_code: assert property (p_code) else $error("bad confirm passed");
  property p_conf;
    unit_cmd_valid |-> $past(cmd_valid, 2) && $past(cmd_opcode, 2) == unit_cmd_opcode;
  endproperty
  a_conf: assert property (p_conf) else $error("confirm not from host");
  property p_idle;
    unit_cmd_valid && unit_cmd_opcode != 8'h35 |-> handoff_valid && handoff_code == 3'h6;
  endproperty
  a_idle: assert property (p_idle) else $error("no idle read handoff");
  property p_route; route_valid |-> $past(read_req); endproperty
  a_route: assert property (p_route) else $error("route without read");
  property p_prog; handoff_valid && handoff_code == 3'h2 |-> $past(cmd_opcode) == 8'h85; endproperty
  a_prog: assert property (p_prog) else $error("program handoff wrong");
  property p_col;
    handoff_valid && handoff_code < 3'h2 |-> $past(cmd_valid) && $past(cmd_opcode) == 8'h05 + handoff_code;
  endproperty
  a_col: assert property (p_col) else $error("column handoff wrong");
  property p_rdy; handoff_valid && handoff_code == 3'h5 |-> $past(unit_ready_change); endproperty
  a_rdy: assert property (p_rdy) else $error("ready handoff wrong");
endmodule

bind nrc_read_fsm nrc_read_fsm_assertions #(.UNITS(UNITS), .UNIT_W(UNIT_W), .ROW_W(ROW_W))
  nrc_read_fsm_assertions_inst (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
  .cmd_opcode(cmd_opcode), .addr_valid(addr_valid), .read_req(read_req),
  .unit_ready_change(unit_ready_change), .unit_read_start(unit_read_start),
  .unit_read_row(unit_read_row), .unit_select(unit_select),
  .unit_out_disable(unit_out_disable), .unit_cmd_valid(unit_cmd_valid),
  .unit_cmd_opcode(unit_cmd_opcode), .route_valid(route_valid),
  .handoff_valid(handoff_valid), .handoff_code(handoff_code));

//--- nrc_host_model.sv
// Behavioural host controller issuing command, address and read cycles.
`timescale 1ns/1ps
module nrc_host_model #(
  parameter int UNITS = 4
) (
  input wire logic pclk,
  input wire logic [UNITS-1:0] unit_idle,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic addr_valid,
  output logic [7:0] addr_byte,
  output logic read_req
);
  initial begin
    cmd_valid = 1'b0;
    addr_valid = 1'b0;
    read_req = 1'b0;
    cmd_opcode = 8'h00;
    addr_byte = 8'h00;
  end
  // Kind 0 is a command, 1 an address byte, 2 a read request.
  // The byte lines invert after a cycle so stale data never looks valid.
  task automatic send(input int k, input logic [7:0] v);
    @(posedge pclk);
    cmd_valid <= (k == 0);
    addr_valid <= (k == 1);
    read_req <= (k == 2);
    cmd_opcode <= v;
    addr_byte <= v;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    addr_valid <= 1'b0;
    read_req <= 1'b0;
    cmd_opcode <= ~v;
    addr_byte <= ~v;
    @(posedge pclk);
  endtask
  task automatic start_read();
    if (unit_idle !== '1) begin
      send(0, nrc_pkg::OP_STATUS_ENH);
    end
    send(0, nrc_pkg::OP_READ);
  endtask
endmodule

//--- nrc_read_fsm_tb.sv
// Self-checking testbench for the read command interpreter.
`timescale 1ns/1ps
module nrc_read_fsm_tb;
  typedef struct {logic [63:0] e; logic [63:0] m;} nrc_note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ready_busy_n;
  logic cmd_valid, addr_valid, read_req, unit_ready_change, unit_read_start;
  logic unit_cmd_valid, route_valid, handoff_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] cmd_opcode, addr_byte, unit_cmd_opcode;
  logic [3:0] unit_idle, unit_select, unit_out_disable;
  logic [23:0] unit_read_row, last_row;
  logic [1:0] route_code;
  logic [2:0] handoff_code;
  logic [15:0] seed = 16'h003c;
  logic [7:0] conf[3] = '{8'h30, 8'h31, 8'h32};
  logic [15:0] cb[9] = '{16'h0005, 16'h0106, 16'h0370, 16'h0478, 16'h0285, 16'h1500,
    16'h2001, 16'h3300, 16'h5000};
  logic [15:0] so[6] = '{16'h3280, 16'h31ee, 16'h333c, 16'h0005, 16'h0106, 16'h4000};
  int n_errors = 0;
  int check_count = 0;
  nrc_note_t q[$];
  nrc_read_fsm nrc_read_fsm_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmd_valid, .cmd_opcode, .addr_valid, .addr_byte,
    .read_req, .ready_busy_n, .unit_idle, .unit_ready_change, .unit_read_start,
    .unit_read_row, .unit_select, .unit_out_disable, .unit_cmd_valid, .unit_cmd_opcode,
    .route_valid, .route_code, .handoff_valid, .handoff_code);
  nrc_host_model nrc_host_model_inst (.pclk, .unit_idle, .cmd_valid, .cmd_opcode,
    .addr_valid, .addr_byte, .read_req);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [63:0] e, input logic [63:0] m = '1);
    q.push_back('{e, m});
  endtask
  task automatic take(input logic [63:0] seen);
    nrc_note_t n;
    if (q.size() == 0) begin
      check(64'h1, 64'h0);
    end else begin
      n = q.pop_front();
      check(seen & n.m, n.e & n.m);
    end
  endtask
  // Results are matched in order against the notes left by the drivers.
  always @(posedge pclk) begin
    if (presetn) begin
      if (unit_cmd_valid) take({4'h3, 52'h0, unit_cmd_opcode});
      if (handoff_valid) take({4'h2, 57'h0, handoff_code});
      if (route_valid) take({4'h1, 58'h0, route_code});
      if (unit_read_start) take({4'h4, 28'h0, unit_select, unit_out_disable, unit_read_row});
      if (psel && penable && pready && !pwrite) take({4'h5, 27'h0, pslverr, prdata});
    end
  end
  task automatic end_of_test();
    check(64'(q.size()), 64'h0);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic err = 1'b0);
    note({4'h5, 27'h0, err, e}, {4'hf, 27'h0, 1'b1, m});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    seed = lfsr(seed);
    unit_idle <= seed[3:0];
    ready_busy_n <= seed[4];
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic run_read(input logic [7:0] cf, input logic off);
    logic [7:0] b[5];
    logic [3:0] sel;
    int n;
    if (!off) begin
      nrc_host_model_inst.start_read();
      rd(nrc_pkg::REG_STATUS, {20'h0, 2'h3, ~ready_busy_n, 9'h003}, 32'h0000_0e0f);
    end
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      b[i] = seed[7:0];
    end
    sel = 4'h1 << b[4][7:6];
    last_row = {b[4], b[3], b[2]};
    note({4'h4, 28'h0, sel, unit_idle & ~sel, b[4], b[3], b[2]});
    for (int i = 0; i < 5; i++) nrc_host_model_inst.send(1, b[i]);
    n = 0;
    while (unit_read_start !== 1'b1 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 50) begin
      n_errors++;
      end_of_test();
    end
    note({4'h3, 52'h0, cf});
    if (cf != 8'h35) note({4'h2, 57'h0, 3'h6});
    nrc_host_model_inst.send(0, cf);
    repeat (3) @(posedge pclk);
  endtask
  task automatic do_act(input logic [15:0] e);
    case (e[15:12])
      4'h0: begin
        note({4'h2, 57'h0, e[10:8]});
        nrc_host_model_inst.send(0, e[7:0]);
      end
      4'h1: begin
        note({4'h2, 57'h0, 3'h5});
        @(posedge pclk);
        unit_ready_change <= 1'b1;
        @(posedge pclk);
        unit_ready_change <= 1'b0;
      end
      4'h2, 4'h3: begin
        apb(1'b1, e[12] ? nrc_pkg::REG_OPCODE : nrc_pkg::REG_CTRL, {24'h0, e[7:0]});
        note({4'h1, 58'h0, e[9:8]});
        nrc_host_model_inst.send(2, 8'h00);
      end
      4'h4: run_read(8'h30, 1'b1);
      default: begin
        nrc_host_model_inst.send(0, nrc_pkg::OP_READ);
        rd(nrc_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_000f);
      end
    endcase
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ready_busy_n = 1'b1;
    unit_idle = 4'hf;
    unit_ready_change = 1'b0;
    do_reset();
    rd(nrc_pkg::REG_CFG, 32'h0000_0005, 32'h0000_0007);
    rd(nrc_pkg::REG_OPCODE, 32'h0000_0000, 32'h0000_00ff);
    rd(12'h020, 32'h0000_0000, '1, 1'b1);
    apb(1'b1, nrc_pkg::REG_OPCODE, 32'h0000_00a5);
    rd(nrc_pkg::REG_OPCODE, 32'h0000_00a5, 32'h0000_00ff);
    foreach (conf[i]) begin
      do_reset();
      run_read(conf[i], 1'b0);
    end
    foreach (cb[i]) begin
      do_reset();
      run_read(8'h35, 1'b0);
      rd(nrc_pkg::REG_STATUS, 32'h0000_1088, 32'h0000_10ff);
      do_act(cb[i]);
    end
    // Software clears only stick while the hardware is not setting the same flag.
    ready_busy_n <= 1'b1;
    apb(1'b1, nrc_pkg::REG_CTRL, 32'h0000_0006);
    rd(nrc_pkg::REG_STATUS, {14'h0, last_row[23:22], 16'h0}, 32'h0003_1200);
    rd(nrc_pkg::REG_ROW, {8'h0, last_row}, 32'hffff_ffff);
    foreach (so[i]) begin
      do_reset();
      apb(1'b1, nrc_pkg::REG_CTRL, 32'h0000_0001);
      nrc_host_model_inst.start_read();
      rd(nrc_pkg::REG_STATUS, 32'h0000_0022, 32'h0000_01ff);
      do_act(so[i]);
    end
    repeat (5) @(posedge pclk);
    end_of_test();
  end
endmodule
